/* rtl/stg_pkg.sv */
package stg_pkg;
  localparam int PRE_STAGES = 2;
  localparam int DIV_STAGES = 21;
  localparam int SEL_STAGE = 7;
  localparam int WARM_STAGE = 14;
  localparam int DVO_STAGE_TOP = 13;
  localparam int TB_STAGE_TOP = 21;
  localparam int WDT_STAGE_LO = 15;
  localparam int TMR_STAGE_LO = 3;
  localparam int TICK_STEP = 2;
  localparam logic [1:0] PRE_LAST = 2'h3;
  localparam logic [1:0] MC_FIRST = 2'h0;
  localparam logic [1:0] MC_LAST = 2'h3;
  localparam logic [3:0] INSTR_MIN = 4'h1;
  localparam logic [3:0] INSTR_MAX = 4'hA;
  localparam logic [7:0] ADDR_TGC = 8'h36;
  localparam logic [7:0] ADDR_SYS2 = 8'h39;
  localparam logic [7:0] ADDR_STAT = 8'h3A;
  localparam logic [7:0] TGC_RESET = 8'h00;
  localparam logic [7:0] SYS2_RESET = 8'h80;

  typedef struct packed {
    logic divider_output_enable;
    logic [1:0] divider_output_rate;
    logic seventh_stage_source_select;
    logic time_base_enable;
    logic [2:0] time_base_rate;
  } stg_tgc_t;

  typedef struct packed {
    logic fast_osc_enable;
    logic slow_osc_enable;
    logic cpu_clock_select;
    logic sleep;
    logic [3:0] reserved;
  } stg_sys2_t;

  typedef struct packed {
    logic tb_tick;
    logic [3:0] wdt_tick;
    logic [7:0] tmr_tick;
  } stg_src_clk_t;
endpackage : stg_pkg

/* rtl/stg_pin_sync.sv */
`timescale 1ns/100ps
module stg_pin_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // pin and result
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic meta;
  logic stab;
  logic prev;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      stab <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      stab <= meta;
      prev <= stab;
    end
  end

  assign level = stab;
  assign rise = stab & ~prev;
endmodule : stg_pin_sync

/* rtl/stg_timing_gen.sv */
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
module stg_timing_gen
  import stg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // oscillator pins
  input wire logic fast_osc_in,
  output logic fast_osc_out,
  input wire logic slow_osc_in,
  output logic slow_osc_out,
  // standby control
  input wire logic stop_enter,
  input wire logic stop_release_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // instruction timing
  input wire logic instr_start,
  input wire logic [3:0] instr_cycles,
  output logic instr_done,
  // derived clocks
  output logic sys_clk_en,
  output logic [1:0] mc_state,
  output logic mc_end,
  output logic divider_pulse_output,
  output stg_src_clk_t src_clk
);
  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WARM} stg_state_t;

  stg_state_t st;
  stg_state_t next_st;
  stg_tgc_t tgc;
  stg_sys2_t sys2;
  logic fast_lvl;
  logic fast_rise;
  logic slow_lvl;
  logic slow_rise;
  logic rel_lvl;
  logic warm_fast;
  logic [PRE_STAGES-1:0] pre;
  logic pre_carry;
  logic [DIV_STAGES:1] div;
  logic [DIV_STAGES:1] in_p;
  logic [DIV_STAGES:1] fall;
  logic clr;
  logic fast_run;
  logic slow_run;
  logic low_speed;
  logic single_clock;
  logic stages_stop;
  logic s7_pulse;
  logic sys_pulse;
  logic warm_done;
  logic [3:0] remain;
  logic dvo_q;

  function automatic logic pick(input logic [DIV_STAGES:1] v, input int idx);
    pick = v[idx];
  endfunction : pick

  function automatic logic [3:0] clamp_cycles(input logic [3:0] n);
    if (n < INSTR_MIN) begin
      clamp_cycles = INSTR_MIN;
    end else if (n > INSTR_MAX) begin
      clamp_cycles = INSTR_MAX;
    end else begin
      clamp_cycles = n;
    end
  endfunction : clamp_cycles

  // oscillator pins, resonator or external square wave
  stg_pin_sync u_fast_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin(fast_osc_in),
    .level(fast_lvl),
    .rise(fast_rise)
  );

  stg_pin_sync u_slow_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin(slow_osc_in),
    .level(slow_lvl),
    .rise(slow_rise)
  );

  stg_pin_sync u_rel_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin(stop_release_n),
    .level(rel_lvl),
    .rise()
  );

  // mode decode
  assign single_clock = ~sys2.slow_osc_enable;
  assign low_speed = sys2.cpu_clock_select & sys2.slow_osc_enable;
  assign fast_run = sys2.fast_osc_enable & (st != ST_STOP);
  assign slow_run = sys2.slow_osc_enable & (st != ST_STOP);
  assign stages_stop = sys2.sleep | (low_speed & ~sys2.fast_osc_enable);

  // oscillator feedback drive
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fast_osc_out <= 1'b0;
      slow_osc_out <= 1'b0;
    end else begin
      fast_osc_out <= fast_run & ~fast_lvl;
      slow_osc_out <= slow_run & ~slow_lvl;
    end
  end

  // stop sequencing
  assign warm_done = (st == ST_WARM) & fall[WARM_STAGE];

  always_comb begin
    next_st = st;
    case (st)
      ST_RUN: begin
        if (stop_enter) begin
          next_st = ST_STOP;
        end
      end
      ST_STOP: begin
        if (!rel_lvl) begin
          next_st = ST_WARM;
        end
      end
      ST_WARM: begin
        if (warm_done) begin
          next_st = ST_RUN;
        end
      end
      default: begin
        next_st = ST_RUN;
      end
    endcase
  end

  assign clr = (st != next_st) & (st != ST_WARM | next_st == ST_RUN);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_RUN;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      warm_fast <= 1'b0;
    end else if (st == ST_RUN && stop_enter) begin
      warm_fast <= ~low_speed & ~sys2.sleep;
    end
  end

  // prescaler
  assign pre_carry = fast_run & fast_rise & (pre == PRE_LAST);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre <= '0;
    end else if (clr) begin
      pre <= '0;
    end else if (fast_run && fast_rise) begin
      pre <= pre + 1'b1;
    end
  end

  // divider stage inputs
  assign in_p[1] = pre_carry & ~stages_stop;

  always_comb begin
    if (st == ST_STOP) begin
      s7_pulse = 1'b0;
    end else if (low_speed || sys2.sleep) begin
      s7_pulse = slow_rise;
    end else if (st == ST_WARM && warm_fast) begin
      s7_pulse = fall[SEL_STAGE-1];
    end else if (tgc.seventh_stage_source_select) begin
      s7_pulse = slow_run & slow_rise;
    end else begin
      s7_pulse = fall[SEL_STAGE-1];
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi <= DIV_STAGES; gi++) begin : g_stage
      assign fall[gi] = in_p[gi] & div[gi];
      if (gi == SEL_STAGE) begin : g_sel
        assign in_p[gi] = s7_pulse;
      end else if (gi > 1) begin : g_chain
        assign in_p[gi] = fall[gi-1];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div <= '0;
    end else if (clr) begin
      div <= '0;
    end else begin
      div <= div ^ in_p;
    end
  end

  // main system clock and machine cycle
  always_comb begin
    if (st != ST_RUN) begin
      sys_pulse = 1'b0;
    end else if (low_speed) begin
      sys_pulse = slow_rise;
    end else begin
      sys_pulse = fast_rise;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mc_state <= MC_FIRST;
      mc_end <= 1'b0;
      sys_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= sys_pulse;
      mc_end <= sys_pulse & (mc_state == MC_LAST);
      if (sys_pulse) begin
        mc_state <= mc_state + 1'b1;
      end
    end
  end

  // instruction length
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      remain <= '0;
      instr_done <= 1'b0;
    end else begin
      instr_done <= 1'b0;
      if (instr_start) begin
        remain <= clamp_cycles(instr_cycles);
      end else if (sys_pulse && mc_state == MC_LAST && remain != '0) begin
        remain <= remain - 1'b1;
        instr_done <= (remain == INSTR_MIN);
      end
    end
  end

  // divider output and source ticks
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dvo_q <= 1'b0;
      divider_pulse_output <= 1'b0;
      src_clk <= '0;
    end else begin
      if (!tgc.divider_output_enable) begin
        dvo_q <= 1'b0;
      end else if (pick(in_p, DVO_STAGE_TOP - int'(tgc.divider_output_rate))) begin
        dvo_q <= ~dvo_q;
      end
      divider_pulse_output <= dvo_q;
      src_clk.tb_tick <= tgc.time_base_enable
        & pick(fall, TB_STAGE_TOP - TICK_STEP * int'(tgc.time_base_rate));
      for (int k = 0; k < 4; k++) begin
        src_clk.wdt_tick[k] <= fall[WDT_STAGE_LO + TICK_STEP * k];
      end
      for (int k = 0; k < 8; k++) begin
        src_clk.tmr_tick[k] <= fall[TMR_STAGE_LO + TICK_STEP * k];
      end
    end
  end

  // register port
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tgc <= TGC_RESET;
    end else if (reg_wr && reg_addr == ADDR_TGC) begin
      tgc <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sys2 <= SYS2_RESET;
    end else if (reg_wr && reg_addr == ADDR_SYS2) begin
      sys2 <= {reg_wdata[7:4], 4'h0};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        ADDR_TGC: reg_rdata <= tgc;
        ADDR_SYS2: reg_rdata <= sys2;
        ADDR_STAT: reg_rdata <= {st == ST_STOP, st == ST_WARM, warm_fast,
          low_speed, single_clock, stages_stop, mc_state};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // checks
  state_wrap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sys_pulse && mc_state == MC_LAST |=> mc_state == MC_FIRST && mc_end)
    else $error("machine cycle did not wrap after state three");

  state_step_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !sys_pulse |=> mc_state == $past(mc_state) && !sys_clk_en)
    else $error("state moved without a system clock");

  stop_clear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st == ST_RUN && stop_enter |=> div == '0 && pre == '0 && st == ST_STOP)
    else $error("counters not cleared on stop entry");

  warm_clear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st == ST_STOP && !rel_lvl |=> div == '0 && st == ST_WARM)
    else $error("counters not cleared on stop release");

  slow_feed_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st != ST_STOP && low_speed && slow_rise |-> in_p[SEL_STAGE])
    else $error("slow clock not fed to stage seven");

  warm_feed_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st == ST_WARM && warm_fast && !low_speed && !sys2.sleep
    |-> in_p[SEL_STAGE] == fall[SEL_STAGE-1])
    else $error("warm-up did not chain stage six");

  fast_sel_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st == ST_RUN && !low_speed && !sys2.sleep && !tgc.seventh_stage_source_select
    |-> in_p[SEL_STAGE] == fall[SEL_STAGE-1])
    else $error("stage seven not fed from fast divide");

  low_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    stages_stop && !clr |=> div[SEL_STAGE-1:1] == $past(div[SEL_STAGE-1:1]))
    else $error("low stages moved while stopped");

  stage_half_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    in_p[2] && !clr |-> $past(div[1]) == 1'b1 || $past(pre_carry))
    else $error("stage two advanced out of turn");

  instr_len_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    instr_start && instr_cycles == INSTR_MAX
    |=> remain == INSTR_MAX)
    else $error("instruction length not loaded");
endmodule : stg_timing_gen

/* sim/stg_osc_model.sv */
`timescale 1ns/100ps
module stg_osc_model #(
  parameter real FAST_HALF = 80.0,
  parameter real SLOW_HALF = 200.0
) (
  // oscillator enables
  input wire logic fast_run,
  input wire logic slow_run,
  // oscillator pins
  output logic fast_osc_in,
  output logic slow_osc_in
);
  // external clocks, output pins left open; phase unrelated to ref_clk
  initial begin
    fast_osc_in = 1'b0;
    #13;
    forever begin
      #(FAST_HALF);
      fast_osc_in = fast_run & ~fast_osc_in;
    end
  end

  initial begin
    slow_osc_in = 1'b0;
    #29;
    forever begin
      #(SLOW_HALF);
      slow_osc_in = slow_run & ~slow_osc_in;
    end
  end
endmodule : stg_osc_model

/* sim/system_timing_generator_tb.sv */
`timescale 1ns/100ps
module system_timing_generator_tb;
  import stg_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic fast_osc_in, slow_osc_in, stop_enter = 1'b0, stop_release_n = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic instr_start = 1'b0, instr_done, sys_clk_en, mc_end, divider_pulse_output;
  logic fast_out, slow_out;
  logic [3:0] instr_cycles = 4'h0, mc_cnt = 4'h0;
  logic [1:0] mc_state;
  stg_src_clk_t src_clk;
  logic [7:0] exp_q[$], msk_q[$];
  logic [3:0] ins_q[$];
  int err_total = 0, samples_checked = 0, cyc = 0, ens;

  stg_osc_model u_stg_osc_model (.fast_run(1'b1), .slow_run(1'b1),
    .fast_osc_in(fast_osc_in), .slow_osc_in(slow_osc_in));
  stg_timing_gen u_stg_timing_gen (.ref_clk(ref_clk), .arst_n(arst_n),
    .fast_osc_in(fast_osc_in), .fast_osc_out(fast_out), .slow_osc_in(slow_osc_in),
    .slow_osc_out(slow_out), .stop_enter(stop_enter), .stop_release_n(stop_release_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr_start(instr_start), .instr_cycles(instr_cycles),
    .instr_done(instr_done), .sys_clk_en(sys_clk_en), .mc_state(mc_state),
    .mc_end(mc_end), .divider_pulse_output(divider_pulse_output), .src_clk(src_clk));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task print_verdict;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge ref_clk);
    exp_q.push_back(e);
    msk_q.push_back(m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd

  function automatic logic hit(input int sel);
    case (sel)
      0: return mc_end;
      1: return src_clk.tmr_tick[0];
      3: return src_clk.tb_tick;
      default: return src_clk.tmr_tick[2];
    endcase
  endfunction : hit

  // cycles between two events of the selected output
  task period(input int sel, input int exp);
    int n;
    n = 0;
    do begin @(posedge ref_clk); #1; n++; end while (!hit(sel) && n < 5000);
    n = 0;
    ens = 0;
    do begin @(posedge ref_clk); #1; n++; ens += sys_clk_en; end
    while (!hit(sel) && n < 5000);
    check(n, exp);
  endtask : period

  task instr(input logic [3:0] n);
    int k;
    ins_q.push_back(n == 4'h0 ? INSTR_MIN : (n > INSTR_MAX ? INSTR_MAX : n));
    do begin @(posedge ref_clk); #1; end while (!mc_end);
    @(posedge ref_clk);
    instr_start <= 1'b1;
    instr_cycles <= n;
    @(posedge ref_clk);
    instr_start <= 1'b0;
    k = 0;
    do begin @(posedge ref_clk); #1; k++; end while (!instr_done && k < 300);
    check(instr_done, 1'b1);
  endtask : instr

  // read data and instruction completion monitor
  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    if (instr_start) mc_cnt <= 4'h0;
    else if (mc_end) mc_cnt <= mc_cnt + 4'h1;
    if (rd_d) check(reg_rdata & msk_q[0], exp_q[0]);
    else if (arst_n) check(reg_rdata, 8'h00);
    if (rd_d) void'(exp_q.pop_front());
    if (rd_d) void'(msk_q.pop_front());
    if (instr_done) check(mc_cnt + {3'h0, mc_end}, ins_q.pop_front());
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      $display("ERROR %0t: run did not finish", $time);
      print_verdict();
    end
  end

  initial begin
    logic [7:0] d;
    void'($urandom(24));
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(ADDR_TGC, TGC_RESET, 8'hFF);
    rd(ADDR_SYS2, SYS2_RESET, 8'hFF);
    rd(ADDR_STAT, 8'h08, 8'hDC);
    wr(8'h37, 8'($urandom));
    rd(8'h37, 8'h00, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom) & 8'hEF;
      wr(ADDR_TGC, d);
      rd(ADDR_TGC, d, 8'hFF);
    end
    wr(ADDR_TGC, 8'h00);
    period(0, 16);
    check(ens, 4);
    period(1, 128);
    period(2, 2048);
    for (int i = 0; i < 12; i++) instr(i[3:0]);
    wr(ADDR_SYS2, 8'hC0);
    wr(ADDR_TGC, 8'hFF);
    period(2, 20);
    period(3, 20);
    wr(ADDR_SYS2, 8'hE0);
    rd(ADDR_STAT, 8'h10, 8'h1C);
    period(0, 40);
    ens = 0;
    repeat (160) begin @(posedge ref_clk); #1; ens += divider_pulse_output; end
    check(ens, 80);
    wr(ADDR_TGC, 8'h00);
    wr(ADDR_SYS2, 8'h60);
    rd(ADDR_STAT, 8'h14, 8'h14);
    period(2, 20);
    wr(ADDR_SYS2, 8'hF0);
    ens = 0;
    repeat (300) begin @(posedge ref_clk); #1; ens += src_clk.tmr_tick[0]; end
    check(ens, 0);
    wr(ADDR_SYS2, 8'h80);
    repeat (20) @(posedge ref_clk);
    @(posedge ref_clk);
    stop_enter <= 1'b1;
    @(posedge ref_clk);
    stop_enter <= 1'b0;
    rd(ADDR_STAT, 8'h80, 8'h80);
    ens = 0;
    repeat (100) begin @(posedge ref_clk); #1; ens += sys_clk_en | fast_out | slow_out; end
    check(ens, 0);
    stop_release_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(ADDR_STAT, 8'h60, 8'hE0);
    wr(ADDR_TGC, 8'hA5);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    stop_release_n <= 1'b1;
    rd(ADDR_STAT, 8'h08, 8'hCC);
    rd(ADDR_TGC, TGC_RESET, 8'hFF);
    repeat (4) @(posedge ref_clk);
    print_verdict();
  end
endmodule : system_timing_generator_tb
